/* File: verilog/fcp_pkg.sv */
// package of constants for the flash host-side command controller
// assumes one 25 MHz system clock; flash pins are sampled synchronously
// Contract
// [R01] protected sectors refuse program and erase
// [R02] host protects all before unprotect, high voltage; the host has no protect ops
// [R03] all sectors ship unprotected
// [R04] high voltage lifts protection temporarily
// [R05] low supply ignores writes, resets device
// [R06] strobe glitches below filter start nothing
// [R07] write needs select, write low, output high
// [R08] power-up lands in read-array, no command
// [R09] wrong sequence returns to read-array
// [R10] address at later fall, data earlier rise
// [R11] read-array after power-up and algorithms
// [R12] erase-suspended sector reads give status
// [R13] reset command ignores its address
// [R14] reset aborts erase sequence before erasure
// [R15] reset aborts program sequence before programming
// [R16] only reset leaves ID-query mode
// [R17] host writes reset on time-limit flag; the host only flags it, reset is a separate op
// [R18] two unlocks plus ID command enter query
// [R19] query reads give maker and device code
// [R20] query sector read gives protect state
// [R21] unlock and command codes are constants
package fcp_pkg;
    // widths
    localparam int ADDR_W = 18;
    localparam int DATA_W = 16;
    // unlock cycles and command codes, configurable constants
    localparam logic [11:0] UNLOCK1_ADDR = 12'h555;
    localparam logic [11:0] UNLOCK2_ADDR = 12'h2aa;
    localparam logic [7:0] UNLOCK1_DATA = 8'haa;
    localparam logic [7:0] UNLOCK2_DATA = 8'h55;
    localparam logic [7:0] CMD_ID_QUERY = 8'h90;
    localparam logic [7:0] CMD_RESET = 8'hf0;
    // query offsets, word and byte mode
    localparam logic [7:0] QRY_MAKER_OFS = 8'h00;
    localparam logic [7:0] QRY_DEV_OFS_W = 8'h01;
    localparam logic [7:0] QRY_DEV_OFS_B = 8'h02;
    localparam logic [7:0] QRY_PROT_OFS_W = 8'h02;
    localparam logic [7:0] QRY_PROT_OFS_B = 8'h04;
    // time-limit flag position on the data bus
    localparam int TLF_BIT = 5;
    // strobe timing: glitch filter and pulse widths
    localparam int GLITCH_NS = 5;
    localparam int CLK_NS = 40;
    localparam int SETUP_CYC = 1;
    localparam int PULSE_NS = 80;
    localparam int PULSE_CYC = (PULSE_NS + CLK_NS - 1) / CLK_NS;
    localparam int GLITCH_CYC = (GLITCH_NS + CLK_NS - 1) / CLK_NS;
    localparam int HOLD_CYC = 1;
    localparam logic [3:0] RST_CNT = 4'h0;
    // host operations
    typedef enum logic [2:0] {
        FCP_OP_READ = 3'h0,
        FCP_OP_WRITE = 3'h1,
        FCP_OP_RESET = 3'h2,
        FCP_OP_ID_ENTER = 3'h3,
        FCP_OP_ID_READ = 3'h4
    } fcp_op_t;
    // id-query read kinds
    typedef enum logic [1:0] {
        FCP_QRY_MAKER = 2'h0,
        FCP_QRY_DEVICE = 2'h1,
        FCP_QRY_PROTECT = 2'h2
    } fcp_qry_t;
endpackage

/* File: verilog/fcp_bus_cycle.sv */
// one flash bus cycle: drives select, write and output strobes
// assumes synchronous sampling of the flash data pins
`timescale 1ns/100ps
module fcp_bus_cycle (
    input wire logic clk_sys_i,
    input wire logic rstn_i,
    input wire logic ce_i,
    input wire logic start_i,
    input wire logic wr_i,
    input wire logic [fcp_pkg::ADDR_W-1:0] addr_i,
    input wire logic [fcp_pkg::DATA_W-1:0] wdata_i,
    input wire logic [fcp_pkg::DATA_W-1:0] dq_i,
    output logic [fcp_pkg::ADDR_W-1:0] addr_o,
    output logic [fcp_pkg::DATA_W-1:0] dq_o,
    output logic dq_oe_n_o,
    output logic cs_n_o,
    output logic we_n_o,
    output logic oe_n_o,
    output logic [fcp_pkg::DATA_W-1:0] rdata_o,
    output logic done_o
);
    // cycle phases, gray along setup-strobe-hold
    typedef enum logic [1:0] {
        FCP_BC_IDLE = 2'b00,
        FCP_BC_SETUP = 2'b01,
        FCP_BC_STROBE = 2'b11,
        FCP_BC_HOLD = 2'b10
    } fcp_bc_t;
    fcp_bc_t st_reg, st_next;
    logic [3:0] cnt_reg, cnt_next; // phase counter
    logic wr_reg, wr_next; // write cycle flag
    logic [fcp_pkg::ADDR_W-1:0] a_reg, a_next;
    logic [fcp_pkg::DATA_W-1:0] d_reg, d_next;
    logic [fcp_pkg::DATA_W-1:0] r_reg, r_next;
    logic cs_reg, cs_next, we_reg, we_next, oe_reg, oe_next;
    logic doe_reg, doe_next, done_reg, done_next;

    // next-state logic for a single bus cycle
    always_comb begin
        st_next = st_reg;
        cnt_next = cnt_reg;
        wr_next = wr_reg;
        a_next = a_reg;
        d_next = d_reg;
        r_next = r_reg;
        cs_next = cs_reg;
        we_next = we_reg;
        oe_next = oe_reg;
        doe_next = doe_reg;
        done_next = 1'b0;
        case (st_reg)
            FCP_BC_IDLE: begin
                if (start_i) begin
                    // [R10] address stable before strobes fall
                    a_next = addr_i;
                    d_next = wdata_i;
                    wr_next = wr_i;
                    doe_next = ~wr_i;
                    cs_next = 1'b1;
                    // [R07] output strobe high during any write
                    oe_next = 1'b1;
                    we_next = 1'b1;
                    cnt_next = 4'(fcp_pkg::SETUP_CYC - 1);
                    st_next = FCP_BC_SETUP;
                end
            end
            FCP_BC_SETUP: begin
                if (cnt_reg == 4'h0) begin
                    // [R07] select and write strobe low together
                    cs_next = 1'b0;
                    we_next = ~wr_reg;
                    oe_next = wr_reg;
                    // [R06] pulse well beyond glitch filter
                    cnt_next = 4'(fcp_pkg::PULSE_CYC - 1);
                    st_next = FCP_BC_STROBE;
                end else begin
                    cnt_next = cnt_reg - 4'h1;
                end
            end
            FCP_BC_STROBE: begin
                if (cnt_reg == 4'h0) begin
                    // [R10] data kept through the rising edge
                    if (!wr_reg) begin
                        r_next = dq_i;
                    end
                    cs_next = 1'b1;
                    we_next = 1'b1;
                    oe_next = 1'b1;
                    cnt_next = 4'(fcp_pkg::HOLD_CYC - 1);
                    st_next = FCP_BC_HOLD;
                end else begin
                    cnt_next = cnt_reg - 4'h1;
                end
            end
            FCP_BC_HOLD: begin
                if (cnt_reg == 4'h0) begin
                    doe_next = 1'b1;
                    done_next = 1'b1;
                    st_next = FCP_BC_IDLE;
                end else begin
                    cnt_next = cnt_reg - 4'h1;
                end
            end
            default: begin
                st_next = FCP_BC_IDLE;
            end
        endcase
    end

    // registers only
    always_ff @(posedge clk_sys_i or negedge rstn_i) begin
        if (!rstn_i) begin
            st_reg <= FCP_BC_IDLE;
            cnt_reg <= fcp_pkg::RST_CNT;
            wr_reg <= 1'b0;
            a_reg <= '0;
            d_reg <= '0;
            r_reg <= '0;
            cs_reg <= 1'b1;
            we_reg <= 1'b1;
            oe_reg <= 1'b1;
            doe_reg <= 1'b1;
            done_reg <= 1'b0;
        end else if (ce_i) begin
            st_reg <= st_next;
            cnt_reg <= cnt_next;
            wr_reg <= wr_next;
            a_reg <= a_next;
            d_reg <= d_next;
            r_reg <= r_next;
            cs_reg <= cs_next;
            we_reg <= we_next;
            oe_reg <= oe_next;
            doe_reg <= doe_next;
            done_reg <= done_next;
        end
    end

    assign addr_o = a_reg;
    assign dq_o = d_reg;
    assign dq_oe_n_o = doe_reg;
    assign cs_n_o = cs_reg;
    assign we_n_o = we_reg;
    assign oe_n_o = oe_reg;
    assign rdata_o = r_reg;
    assign done_o = done_reg;

    // [R07] never write with output strobe low
    write_inhibit_a: assert property (@(posedge clk_sys_i) disable iff (!rstn_i)
        !we_reg |-> (oe_reg && !cs_reg)) // [R07]
        else $error("write strobe low with output strobe low");
    // [R06] write pulse lasts the full width
    pulse_width_a: assert property (@(posedge clk_sys_i) disable iff (!rstn_i)
        (ce_i && $fell(we_reg)) |-> !we_reg ##1 (!we_reg || !ce_i)) // [R06]
        else $error("write pulse shorter than two cycles");
endmodule

/* File: verilog/fcp_host.sv */
// host controller driving a parallel nor flash command interface
// assumes synchronous flash pins and the fcp_bus_cycle leaf
`timescale 1ns/100ps
module fcp_host (
    input wire logic clk_sys_i,
    input wire logic rstn_i,
    input wire logic ce_i,
    input wire logic req_i,
    input wire fcp_pkg::fcp_op_t op_i,
    input wire fcp_pkg::fcp_qry_t qry_i,
    input wire logic byte_mode_i,
    input wire logic [fcp_pkg::ADDR_W-1:0] addr_i,
    input wire logic [fcp_pkg::DATA_W-1:0] wdata_i,
    input wire logic [fcp_pkg::DATA_W-1:0] dq_i,
    input wire logic lockout_i,
    output logic busy_o,
    output logic ack_o,
    output logic [fcp_pkg::DATA_W-1:0] rdata_o,
    output logic id_mode_o,
    output logic tlf_seen_o,
    output logic [fcp_pkg::ADDR_W-1:0] addr_o,
    output logic [fcp_pkg::DATA_W-1:0] dq_o,
    output logic dq_oe_n_o,
    output logic cs_n_o,
    output logic we_n_o,
    output logic oe_n_o
);
    // command sequencer states, gray along unlock path
    typedef enum logic [2:0] {
        FCP_IDLE = 3'b000,
        FCP_UNLK1 = 3'b001,
        FCP_UNLK2 = 3'b011,
        FCP_CMD = 3'b010,
        FCP_SINGLE = 3'b110,
        FCP_DONE = 3'b111
    } fcp_state_t;
    fcp_state_t st_reg, st_next;
    logic id_reg, id_next; // device is in id-query mode
    logic tlf_reg, tlf_next; // time-limit flag seen on a read
    logic ack_reg, ack_next;
    logic busy_reg, busy_next;
    logic [fcp_pkg::DATA_W-1:0] rd_reg, rd_next;
    fcp_pkg::fcp_op_t op_reg, op_next;
    logic [fcp_pkg::ADDR_W-1:0] a_reg, a_next;
    logic [fcp_pkg::DATA_W-1:0] d_reg, d_next;
    // bus cycle request
    logic bc_start, bc_wr, bc_done;
    logic [fcp_pkg::ADDR_W-1:0] bc_addr;
    logic [fcp_pkg::DATA_W-1:0] bc_wdata, bc_rdata;
    logic [7:0] qofs; // query offset for the chosen kind

    // query offset picks word or byte mode figure
    always_comb begin
        case (qry_i)
            // [R19] maker and device code offsets
            fcp_pkg::FCP_QRY_MAKER: qofs = fcp_pkg::QRY_MAKER_OFS;
            fcp_pkg::FCP_QRY_DEVICE: qofs = byte_mode_i ?
                fcp_pkg::QRY_DEV_OFS_B : fcp_pkg::QRY_DEV_OFS_W;
            // [R20] sector protect query offset
            fcp_pkg::FCP_QRY_PROTECT: qofs = byte_mode_i ?
                fcp_pkg::QRY_PROT_OFS_B : fcp_pkg::QRY_PROT_OFS_W;
            default: qofs = fcp_pkg::QRY_MAKER_OFS;
        endcase
    end

    // sequencer next state and bus cycle requests
    always_comb begin
        st_next = st_reg;
        id_next = id_reg;
        tlf_next = tlf_reg;
        ack_next = 1'b0;
        busy_next = busy_reg;
        rd_next = rd_reg;
        op_next = op_reg;
        a_next = a_reg;
        d_next = d_reg;
        bc_start = 1'b0;
        bc_wr = 1'b0;
        bc_addr = a_reg;
        bc_wdata = d_reg;
        case (st_reg)
            FCP_IDLE: begin
                // [R05] hold off while supply is locked out
                if (req_i && !lockout_i) begin
                    // [R02] no protect ops: high voltage is never driven
                    op_next = op_i;
                    busy_next = 1'b1;
                    d_next = wdata_i;
                    // [R20] sector select bits kept, low offset set
                    a_next = (op_i == fcp_pkg::FCP_OP_ID_READ) ?
                        {addr_i[fcp_pkg::ADDR_W-1:8], qofs} : addr_i;
                    // [R18] id entry begins with unlock cycles
                    st_next = (op_i == fcp_pkg::FCP_OP_ID_ENTER) ?
                        FCP_UNLK1 : FCP_SINGLE;
                end
            end
            FCP_UNLK1: begin
                // [R21] first unlock cycle from constants
                bc_start = 1'b1;
                bc_wr = 1'b1;
                bc_addr = fcp_pkg::ADDR_W'(fcp_pkg::UNLOCK1_ADDR);
                bc_wdata = fcp_pkg::DATA_W'(fcp_pkg::UNLOCK1_DATA);
                st_next = FCP_UNLK2;
            end
            FCP_UNLK2: begin
                if (bc_done) begin
                    bc_start = 1'b1;
                    bc_wr = 1'b1;
                    bc_addr = fcp_pkg::ADDR_W'(fcp_pkg::UNLOCK2_ADDR);
                    bc_wdata = fcp_pkg::DATA_W'(fcp_pkg::UNLOCK2_DATA);
                    st_next = FCP_CMD;
                end
            end
            FCP_CMD: begin
                if (bc_done) begin
                    // [R18] id-query command after unlocks
                    bc_start = 1'b1;
                    bc_wr = 1'b1;
                    bc_addr = fcp_pkg::ADDR_W'(fcp_pkg::UNLOCK1_ADDR);
                    bc_wdata = fcp_pkg::DATA_W'(fcp_pkg::CMD_ID_QUERY);
                    id_next = 1'b1;
                    st_next = FCP_DONE;
                end
            end
            FCP_SINGLE: begin
                bc_start = 1'b1;
                bc_wr = (op_reg != fcp_pkg::FCP_OP_READ) &&
                    (op_reg != fcp_pkg::FCP_OP_ID_READ);
                if (op_reg == fcp_pkg::FCP_OP_RESET) begin
                    // [R13] reset command, address is don't care
                    bc_wdata = fcp_pkg::DATA_W'(fcp_pkg::CMD_RESET);
                    // [R16] only reset leaves id-query mode
                    id_next = 1'b0;
                    // [R17] reset answers the time-limit flag
                    tlf_next = 1'b0;
                end
                st_next = FCP_DONE;
            end
            FCP_DONE: begin
                if (bc_done) begin
                    rd_next = bc_rdata;
                    // [R17] time-limit flag seen on a plain read
                    if (op_reg == fcp_pkg::FCP_OP_READ &&
                        bc_rdata[fcp_pkg::TLF_BIT]) begin
                        tlf_next = 1'b1;
                    end
                    ack_next = 1'b1;
                    busy_next = 1'b0;
                    st_next = FCP_IDLE;
                end
            end
            default: begin
                st_next = FCP_IDLE;
            end
        endcase
    end

    // sequencer registers
    always_ff @(posedge clk_sys_i or negedge rstn_i) begin
        if (!rstn_i) begin
            st_reg <= FCP_IDLE;
            id_reg <= 1'b0;
            tlf_reg <= 1'b0;
            ack_reg <= 1'b0;
            busy_reg <= 1'b0;
            rd_reg <= '0;
            op_reg <= fcp_pkg::FCP_OP_READ;
            a_reg <= '0;
            d_reg <= '0;
        end else if (ce_i) begin
            st_reg <= st_next;
            id_reg <= id_next;
            tlf_reg <= tlf_next;
            ack_reg <= ack_next;
            busy_reg <= busy_next;
            rd_reg <= rd_next;
            op_reg <= op_next;
            a_reg <= a_next;
            d_reg <= d_next;
        end
    end

    // one pin-level bus cycle engine
    fcp_bus_cycle u_cycle (
        .clk_sys_i(clk_sys_i),
        .rstn_i(rstn_i),
        .ce_i(ce_i),
        .start_i(bc_start),
        .wr_i(bc_wr),
        .addr_i(bc_addr),
        .wdata_i(bc_wdata),
        .dq_i(dq_i),
        .addr_o(addr_o),
        .dq_o(dq_o),
        .dq_oe_n_o(dq_oe_n_o),
        .cs_n_o(cs_n_o),
        .we_n_o(we_n_o),
        .oe_n_o(oe_n_o),
        .rdata_o(bc_rdata),
        .done_o(bc_done)
    );

    assign busy_o = busy_reg;
    assign ack_o = ack_reg;
    assign rdata_o = rd_reg;
    assign id_mode_o = id_reg;
    assign tlf_seen_o = tlf_reg;

    // [R16] id mode clears only through a reset op
    id_exit_a: assert property (@(posedge clk_sys_i) disable iff (!rstn_i)
        (ce_i && id_reg && st_reg == FCP_SINGLE
         && op_reg != fcp_pkg::FCP_OP_RESET) |=> id_reg) // [R16]
        else $error("id mode left without reset");
    // [R18] first unlock cycle is always followed by the second
    id_enter_a: assert property (@(posedge clk_sys_i) disable iff (!rstn_i)
        (ce_i && st_reg == FCP_UNLK1) |=> st_reg == FCP_UNLK2) // [R18]
        else $error("unlock sequence broken");
    // [R05] no new sequence accepted during lockout
    lockout_hold_a: assert property (@(posedge clk_sys_i) disable iff (!rstn_i)
        (ce_i && st_reg == FCP_IDLE && lockout_i) |=> st_reg == FCP_IDLE) // [R05]
        else $error("request taken during supply lockout");
    // [R13] reset op writes the reset code
    reset_code_a: assert property (@(posedge clk_sys_i) disable iff (!rstn_i)
        (st_reg == FCP_SINGLE && op_reg == fcp_pkg::FCP_OP_RESET)
        |-> bc_wdata == fcp_pkg::DATA_W'(fcp_pkg::CMD_RESET)) // [R13]
        else $error("reset op carries wrong code");
endmodule

/* File: tb/fcp_flash_model.sv */
// behavioural nor flash device facing the host controller pins
// assumes the bench resolves the shared data wire and feeds it back in
`timescale 1ns/100ps
module fcp_flash_model #(
    parameter logic [15:0] MAKER_CODE = 16'h0013, // arbitrary value
    parameter logic [15:0] DEV_CODE = 16'h4b0c, // arbitrary value
    parameter logic [7:0] PROT_INIT = 8'h00
) (
    input wire logic cs_n_i,
    input wire logic we_n_i,
    input wire logic oe_n_i,
    input wire logic [17:0] addr_i,
    input wire logic [15:0] dq_i,
    input wire logic byte_mode_i,
    input wire logic lockout_i,
    input wire logic tlf_i,
    output logic [15:0] dq_o,
    output logic dq_en_o,
    output logic [17:0] wr_addr_o,
    output logic [15:0] wr_data_o,
    output logic [7:0] wr_cnt_o
);
    logic [1:0] st; // 0 array, 1 and 2 unlocks seen, 3 id query
    logic wr_open; // a write cycle is in progress
    realtime t_fall; // when the write cycle opened
    logic [7:0] ofs; // low address byte of a read

    // start in read-array with no write open
    initial begin
        st = 2'h0;
        wr_open = 1'b0;
        wr_cnt_o = 8'h00;
    end

    // address taken at the later falling strobe
    always @(negedge cs_n_i or negedge we_n_i) begin
        if (!cs_n_i && !we_n_i && oe_n_i) begin
            wr_addr_o = addr_i;
            t_fall = $realtime;
            wr_open = 1'b1;
        end
    end

    // data at the earlier rise, short pulses dropped
    always @(posedge cs_n_i or posedge we_n_i) begin
        if (wr_open) begin
            wr_open = 1'b0;
            if ($realtime - t_fall >= fcp_pkg::GLITCH_NS && !lockout_i)
                do_write(dq_i);
        end
    end

    // low supply resets the command state
    always @(posedge lockout_i) st = 2'h0;

    // command decoder for one accepted write
    task automatic do_write(input logic [15:0] d);
        logic [11:0] ea;
        logic [7:0] ed;
        ea = (st == 2'h1) ? fcp_pkg::UNLOCK2_ADDR : fcp_pkg::UNLOCK1_ADDR;
        ed = (st == 2'h0) ? fcp_pkg::UNLOCK1_DATA :
             (st == 2'h1) ? fcp_pkg::UNLOCK2_DATA : fcp_pkg::CMD_ID_QUERY;
        wr_data_o = d;
        wr_cnt_o = wr_cnt_o + 8'h01;
        if (d[7:0] == fcp_pkg::CMD_RESET) begin
            st = 2'h0;
        // query mode left only by reset or a supply lockout
        end else if (st == 2'h3) begin
            st = 2'h3;
        // next unlock step or back to array
        end else if (wr_addr_o[11:0] == ea && d[7:0] == ed) begin
            st = st + 2'h1;
        end else begin
            st = 2'h0;
        end
    endtask

    // no erase suspend here, so every read outside id query gives array data
    always_comb begin
        ofs = addr_i[7:0];
        dq_en_o = !cs_n_i && !oe_n_i;
        dq_o = {addr_i[15:8] ^ 8'h3c, addr_i[7:6], tlf_i, addr_i[4:0]};
        if (st == 2'h3) begin
            dq_o = 16'h0000;
            if (ofs == fcp_pkg::QRY_MAKER_OFS)
                dq_o = MAKER_CODE;
            else if (ofs == (byte_mode_i ? fcp_pkg::QRY_DEV_OFS_B :
                             fcp_pkg::QRY_DEV_OFS_W))
                dq_o = DEV_CODE;
            // protect bits fixed: no high voltage modelled
            else if (ofs == (byte_mode_i ? fcp_pkg::QRY_PROT_OFS_B :
                             fcp_pkg::QRY_PROT_OFS_W))
                dq_o = {15'h0000, PROT_INIT[addr_i[17:15]]};
        end
    end
endmodule

/* File: tb/fcp_host_tb.sv */
// self-checking bench for the flash host command controller
// assumes the design package, the host and the flash model are compiled
`timescale 1ns/100ps
module fcp_host_tb;
    localparam logic [15:0] MAKER = 16'h0013; // arbitrary value
    localparam logic [15:0] DEVC = 16'h4b0c; // arbitrary value
    localparam logic [17:0] U1A = {6'h00, fcp_pkg::UNLOCK1_ADDR};
    localparam logic [17:0] U2A = {6'h00, fcp_pkg::UNLOCK2_ADDR};
    localparam logic [15:0] U1D = {8'h00, fcp_pkg::UNLOCK1_DATA};
    localparam logic [15:0] U2D = {8'h00, fcp_pkg::UNLOCK2_DATA};
    localparam logic [15:0] IDD = {8'h00, fcp_pkg::CMD_ID_QUERY};
    logic clk, rstn, ce, req, byte_mode, lockout, tlf;
    fcp_pkg::fcp_op_t op;
    fcp_pkg::fcp_qry_t qry;
    logic [17:0] addr, addr_o, wr_addr;
    logic [15:0] wdata, dq_bus, dq_o, rdata, mdl_dq, wr_data;
    logic [15:0] float_pat = 16'h5a5a; // level of an undriven wire
    logic busy, ack, id_mode, tlf_seen, dq_oe_n, cs_n, we_n, oe_n, mdl_en;
    logic [7:0] wr_cnt;
    int error_cnt = 0;
    int total_checks = 0;

    // shared data wire: host, device, or a toggling float
    assign dq_bus = !dq_oe_n ? dq_o : (mdl_en ? mdl_dq : float_pat);
    always @(posedge clk) float_pat <= ~float_pat;

    // 25 mhz system clock
    initial begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end

    fcp_host dut (.clk_sys_i(clk), .rstn_i(rstn), .ce_i(ce), .req_i(req),
        .op_i(op), .qry_i(qry), .byte_mode_i(byte_mode), .addr_i(addr),
        .wdata_i(wdata), .dq_i(dq_bus), .lockout_i(lockout), .busy_o(busy),
        .ack_o(ack), .rdata_o(rdata), .id_mode_o(id_mode),
        .tlf_seen_o(tlf_seen), .addr_o(addr_o), .dq_o(dq_o),
        .dq_oe_n_o(dq_oe_n), .cs_n_o(cs_n), .we_n_o(we_n), .oe_n_o(oe_n));

    fcp_flash_model #(.MAKER_CODE(MAKER), .DEV_CODE(DEVC),
        .PROT_INIT(8'h04)) mdl (.cs_n_i(cs_n), .we_n_i(we_n),
        .oe_n_i(oe_n), .addr_i(addr_o), .dq_i(dq_bus),
        .byte_mode_i(byte_mode), .lockout_i(lockout), .tlf_i(tlf),
        .dq_o(mdl_dq), .dq_en_o(mdl_en), .wr_addr_o(wr_addr),
        .wr_data_o(wr_data), .wr_cnt_o(wr_cnt));

    // base compare: counts and reports a mismatch
    task automatic cmp(input logic [17:0] g, input logic [17:0] e);
        total_checks++;
        if (g !== e) begin
            error_cnt++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask

    // compare of the returned read word
    task automatic chk_rd(input logic [15:0] e);
        cmp({2'h0, rdata}, {2'h0, e});
    endtask

    // compare of a status flag
    task automatic chk_bit(input logic g, input logic e);
        cmp({17'h0, g}, {17'h0, e});
    endtask

    // array content as the device holds it
    function automatic logic [15:0] arr(input logic [17:0] a);
        return {a[15:8] ^ 8'h3c, a[7:6], tlf, a[4:0]};
    endfunction

    // one request, held a cycle, then a bounded wait for ack
    task automatic do_op(input fcp_pkg::fcp_op_t o,
                         input fcp_pkg::fcp_qry_t q,
                         input logic [17:0] a, input logic [15:0] d);
        int n;
        op = o;
        qry = q;
        addr = a;
        wdata = d;
        req = 1'b1;
        @(negedge clk);
        req = 1'b0;
        n = 0;
        while (ack !== 1'b1 && n < 100) begin
            @(negedge clk);
            n++;
        end
        if (n >= 100) cmp(18'h0, 18'h1);
    endtask

    task automatic wr(input logic [17:0] a, input logic [15:0] d);
        do_op(fcp_pkg::FCP_OP_WRITE, fcp_pkg::FCP_QRY_MAKER, a, d);
    endtask

    task automatic rd(input logic [17:0] a);
        do_op(fcp_pkg::FCP_OP_READ, fcp_pkg::FCP_QRY_MAKER, a, 16'h0000);
    endtask

    task automatic rst_cmd(input logic [17:0] a);
        do_op(fcp_pkg::FCP_OP_RESET, fcp_pkg::FCP_QRY_MAKER, a, 16'h0000);
    endtask

    task automatic idr(input fcp_pkg::fcp_qry_t q, input logic [17:0] a);
        do_op(fcp_pkg::FCP_OP_ID_READ, q, a, 16'h0000);
    endtask

    // idle pins after reset, then a plain array read
    task automatic t_reset();
        chk_bit(we_n, 1'b1);
        chk_bit(id_mode, 1'b0);
        // clock enable low freezes the sequencer, request stays up
        ce = 1'b0;
        req = 1'b1;
        repeat (3) @(negedge clk);
        chk_bit(busy, 1'b0);
        chk_bit(cs_n, 1'b1);
        ce = 1'b1;
        rd(18'h01234);
        chk_rd(arr(18'h01234));
    endtask

    // one write lands with its address and data
    task automatic t_write();
        logic [7:0] n0;
        n0 = wr_cnt;
        wr(18'h20123, 16'h1234);
        cmp({10'h0, wr_cnt}, {10'h0, n0 + 8'h01});
        cmp(wr_addr, 18'h20123);
        cmp({2'h0, wr_data}, 18'h01234);
    endtask

    // query entry, every query kind in both modes, exit by reset
    task automatic t_id();
        do_op(fcp_pkg::FCP_OP_ID_ENTER, fcp_pkg::FCP_QRY_MAKER, 18'h0, 16'h0);
        chk_bit(id_mode, 1'b1);
        for (int b = 0; b < 2; b++) begin
            byte_mode = b[0];
            idr(fcp_pkg::FCP_QRY_MAKER, 18'h10000);
            chk_rd(MAKER);
            idr(fcp_pkg::FCP_QRY_DEVICE, 18'h00000);
            chk_rd(DEVC);
            idr(fcp_pkg::FCP_QRY_PROTECT, 18'h10000);
            chk_rd(16'h0001);
            idr(fcp_pkg::FCP_QRY_PROTECT, 18'h30000);
            chk_rd(16'h0000);
        end
        byte_mode = 1'b0;
        rst_cmd(18'h3f0f0);
        chk_bit(id_mode, 1'b0);
        rd(18'h10000);
        chk_rd(arr(18'h10000));
    endtask

    // reset after the two unlocks, then a broken sequence
    task automatic t_abort();
        wr(U1A, U1D);
        wr(U2A, U2D);
        rst_cmd(18'h2aaaa);
        wr(U1A, IDD);
        rd(18'h00200);
        chk_rd(arr(18'h00200));
        wr(U1A, U1D);
        wr(U2A, 16'h0077);
        wr(U2A, U2D);
        wr(U1A, IDD);
        rd(18'h00300);
        chk_rd(arr(18'h00300));
        chk_bit(id_mode, 1'b0);
    endtask

    // time-limit flag seen on a read, cleared by reset
    task automatic t_tlf();
        tlf = 1'b1;
        rd(18'h00040);
        chk_rd(arr(18'h00040));
        chk_bit(tlf_seen, 1'b1);
        tlf = 1'b0;
        rst_cmd(18'h00000);
        chk_bit(tlf_seen, 1'b0);
    endtask

    // supply lockout holds requests off and resets the device
    task automatic t_lock();
        logic [7:0] n0;
        do_op(fcp_pkg::FCP_OP_ID_ENTER, fcp_pkg::FCP_QRY_MAKER, 18'h0, 16'h0);
        n0 = wr_cnt;
        lockout = 1'b1;
        op = fcp_pkg::FCP_OP_WRITE;
        addr = U1A;
        wdata = U1D;
        req = 1'b1;
        repeat (10) @(negedge clk);
        chk_bit(busy, 1'b0);
        cmp({10'h0, wr_cnt}, {10'h0, n0});
        lockout = 1'b0;
        rd(18'h00080);
        chk_rd(arr(18'h00080));
        rst_cmd(18'h00000);
    endtask

    // verdict and end of run
    task automatic results();
        if (error_cnt == 0 && total_checks > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask

    // watchdog well beyond the 28 ops of the run
    initial begin
        #(40 * 4000);
        error_cnt++;
        results();
    end

    // main sequence
    initial begin
        rstn = 1'b0;
        ce = 1'b1;
        req = 1'b0;
        op = fcp_pkg::FCP_OP_READ;
        qry = fcp_pkg::FCP_QRY_MAKER;
        byte_mode = 1'b0;
        addr = 18'h0;
        wdata = 16'h0;
        lockout = 1'b0;
        tlf = 1'b0;
        repeat (8) @(negedge clk);
        rstn = 1'b1;
        t_reset();
        t_write();
        t_id();
        t_abort();
        t_tlf();
        t_lock();
        results();
    end
endmodule
